// ---- lmb_blitter.sv ----
// How it works
// - Signed X/Y steps, zero allowed; start addresses are the first bytes used.
// - Each new row starts at previous row start plus Y step.
// - Width and height are count minus one; width has a ninth bit.
// - Source byte is ANDed with AND mask then XORed with XOR mask.
// - Bytes repeat X-zoom times, rows Y-zoom times; destination steps every repetition.
// - Pattern mode repeats first 1 to 128 source bytes of a row, after zoom.
// - Mode selects copy, byte stencil, add, OR, AND, XOR or nibble stencil.
// - Nibble stencil writes only non-zero source nibbles.
// - Next bit chains to the entry stored directly after the current one.
// - Loading an entry takes 21 granted memory cycles before data transfers.
// - Collision when non-transparent source meets non-transparent destination; never in copy.
// - Eight mask bits each enable one group of 32 destination byte values.
// - In nibble mode each mask group spans two nibble values.
// - First collision of a blit stores the destination value, nibble-wise in mode 6.
// - Blitter uses only free memory cycles, at lowest priority.
// - Copy takes two cycles; byte stencil one, two or three.
// - Add, OR, XOR, nibble take one or three; AND two or three.
// - Zero fast path tests the masked source value.
// - Zero AND mask or X-zoom repetition skips refetching the source, except a zero source outside copy and AND.
// - Eight-slot pattern: window reads slot 1, writes slot 3, overlay even slots.
// - Low-res overlay uses slots 0 and 4, others all even slots.
// - After the overlay region a 22-cycle display-list window; unused slots go to blitter.
// - Optional host interrupt when the last entry of a list completes.
// - Collision code clears to zero at the start of every blit.
// - Start addresses are 24 bits, low byte first.
// - Blitter memory steps advance only on cycles granted to it.
module lmb_blitter
	import lmb_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	input  wire lmb_slot_req_s slot_req,
	output lmb_grant_s         grant,
	output logic               dl_window,
	output lmb_mem_s           mem,
	input  wire logic [7:0]    mem_rdata,
	output logic               list_done_irq
);

	typedef struct packed {
		lmb_state_e       st;
		logic [2:0]       slot;
		logic             ovl_q;
		logic [4:0]       dlres;
		logic             ack;
		logic [31:0]      dat;
		logic [23:0]      list;
		logic [23:0]      lptr;
		logic             irq_en;
		logic             busy;
		logic             irq;
		logic [20:0][7:0] ent;
		logic [4:0]       idx;
		logic [4:0]       cidx;
		logic             pend;
		logic [4:0]       lcnt;
		logic [23:0]      src;
		logic [23:0]      srow;
		logic [23:0]      dst;
		logic [23:0]      drow;
		logic [8:0]       x;
		logic [7:0]       y;
		logic [2:0]       zx;
		logic [2:0]       zy;
		logic [6:0]       pc;
		logic [7:0]       sq;
		logic [7:0]       dq;
		logic [7:0]       wd;
		logic [7:0]       code;
		logic             cfound;
		logic [23:0]      maddr;
	} lmb_state_s;

	lmb_state_s q, n;

	// Signed step widening
	function automatic logic [23:0] sext8(input logic [7:0] v);
		return {{16{v[7]}}, v};
	endfunction

	function automatic logic [23:0] sext13(input logic [12:0] v);
		return {{11{v[12]}}, v};
	endfunction

	// Zero source needs no destination access except in copy and AND
	function automatic logic fast_zero(input logic [2:0] m, input logic [7:0] s);
		return (s == 8'h00) && (m != M_COPY) && (m != M_AND) && (m <= M_NIBBLE);
	endfunction

	// Next access step once the masked source byte is known
	function automatic lmb_state_e route(input logic [2:0] m, input logic [7:0] s,
			input logic cm_any);
		if (m == M_COPY || m > M_NIBBLE) begin
			return ST_DST_WR;
		end else if (s == 8'h00) begin
			return (m == M_AND) ? ST_DST_WR : ST_ADV;
		end else if (m == M_BSTEN && !cm_any) begin
			return ST_DST_WR;
		end else begin
			return ST_DST_RD;
		end
	endfunction

	function automatic logic [7:0] merge(input logic [2:0] m, input logic [7:0] s,
			input logic [7:0] d);
		case (m)
			M_ADD:    return s + d;
			M_OR:     return s | d;
			M_AND:    return s & d;
			M_XOR:    return s ^ d;
			M_NIBBLE: return {(s[7:4] != 4'h0) ? s[7:4] : d[7:4],
					(s[3:0] != 4'h0) ? s[3:0] : d[3:0]};
			default:  return s;
		endcase
	endfunction

	logic [7:0]  reg_addr;
	logic        bus_new;
	logic        start_req;
	logic        blt_req;
	logic [2:0]  mode;
	logic [7:0]  cmask;
	logic [2:0]  zoomx;
	logic [2:0]  zoomy;
	logic [8:0]  width;
	logic [23:0] sx_step;
	logic [23:0] dx_step;
	logic [23:0] sy_step;
	logic [23:0] dy_step;

	// Entry fields as the running blit sees them
	assign mode     = q.ent[E_MODE][2:0];
	assign cmask    = q.ent[E_CM];
	assign zoomx    = q.ent[E_ZOOM][2:0];
	assign zoomy    = q.ent[E_ZOOM][6:4];
	assign width    = {q.ent[E_W8][0], q.ent[E_W]};
	assign sx_step  = sext8(q.ent[E_SX]);
	assign dx_step  = sext8(q.ent[E_DX]);
	assign sy_step  = sext13({q.ent[E_SY + 1][4:0], q.ent[E_SY]});
	assign dy_step  = sext13({q.ent[E_DY + 1][4:0], q.ent[E_DY]});

	assign reg_addr  = {wb_adr_i[7:2], 2'b00};
	assign bus_new   = wb_cyc_i && wb_stb_i && !q.ack;
	assign start_req = bus_new && wb_we_i && reg_addr == REG_CTRL && wb_sel_i[0]
			&& wb_dat_i[CTRL_START_BIT];

	// Fixed slot priority; window and overlay never share a slot
	assign grant.win = (q.slot == SLOT_WIN_RD && slot_req.win_rd)
			|| (q.slot == SLOT_WIN_WR && slot_req.win_wr);
	assign grant.ovl = slot_req.ovl_active && !q.slot[0]
			&& (slot_req.ovl_mode != OVL_LOW || !q.slot[1]);
	assign grant.dl  = slot_req.dl_req && !grant.win && !grant.ovl;
	assign blt_req   = q.st == ST_LOAD || q.st == ST_SRC_RD || q.st == ST_DST_RD
			|| q.st == ST_DST_WR;
	assign grant.blt = blt_req && !grant.win && !grant.ovl && !grant.dl;

	// Outputs straight from state
	assign wb_ack_o      = q.ack;
	assign wb_dat_o      = q.dat;
	assign dl_window     = q.dlres != 5'h00;
	assign list_done_irq = q.irq;
	assign mem.req       = blt_req;
	assign mem.we        = q.st == ST_DST_WR;
	assign mem.addr      = q.maddr;
	assign mem.wdata     = q.wd;

	// Whole block next state
	always_comb begin
		logic       lastx;
		logic       skip;
		logic       done;
		logic [7:0] s;
		logic [7:0] d;
		lastx = 1'b0;
		skip  = 1'b0;
		done  = 1'b0;
		s     = 8'h00;
		d     = 8'h00;
		n     = q;
		n.irq = 1'b0;

		// Slot counter and display-list reservation after the overlay region
		n.slot  = q.slot + 3'h1;
		n.ovl_q = slot_req.ovl_active;
		if (q.ovl_q && !slot_req.ovl_active) begin
			n.dlres = DL_RESERVE;
		end else if (q.dlres != 5'h00) begin
			n.dlres = q.dlres - 5'h01;
		end

		// Entry byte lands one cycle after its read
		if (q.pend) begin
			n.ent[q.cidx] = mem_rdata;
			n.pend        = 1'b0;
		end

		// Wishbone slave: answer one cycle after the request
		n.ack = bus_new;
		if (bus_new) begin
			if (reg_addr == REG_LIST) begin
				n.dat = {8'h00, q.list};
			end else if (reg_addr == REG_CTRL) begin
				n.dat = 32'h0000_0000;
				n.dat[CTRL_IRQEN_BIT] = q.irq_en;
				n.dat[STAT_BUSY_BIT]  = q.busy;
			end else if (reg_addr == REG_COLL) begin
				n.dat = {24'h000000, q.code};
			end else begin
				n.dat = 32'h0000_0000;
			end
			if (wb_we_i && reg_addr == REG_LIST) begin
				for (int i = 0; i < 3; i++) begin
					if (wb_sel_i[i]) begin
						n.list[8 * i +: 8] = wb_dat_i[8 * i +: 8];
					end
				end
			end else if (wb_we_i && reg_addr == REG_CTRL && wb_sel_i[0]) begin
				n.irq_en = wb_dat_i[CTRL_IRQEN_BIT];
			end
		end

		case (q.st)
			ST_IDLE: begin
				// Start while busy is ignored
				if (start_req) begin
					n.busy = 1'b1;
					n.lptr = q.list;
					n.idx  = 5'h00;
					n.lcnt = 5'h00;
					n.st   = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (grant.blt) begin
					n.pend = 1'b1;
					n.cidx = q.idx;
					n.lcnt = q.lcnt + 5'h01;
					if (q.idx == ENTRY_BYTES - 5'h01) begin
						n.st = ST_SETUP;
					end else begin
						n.idx = q.idx + 5'h01;
					end
				end
			end
			ST_SETUP: begin
				// n.ent already holds the final byte here
				n.src    = {n.ent[E_SRC + 2], n.ent[E_SRC + 1], n.ent[E_SRC]};
				n.srow   = n.src;
				n.dst    = {n.ent[E_DST + 2], n.ent[E_DST + 1], n.ent[E_DST]};
				n.drow   = n.dst;
				n.x      = 9'h000;
				n.y      = 8'h00;
				n.zx     = 3'h0;
				n.zy     = 3'h0;
				n.pc     = 7'h00;
				n.code   = 8'h00;
				n.cfound = 1'b0;
				n.st     = ST_SRC_RD;
			end
			ST_SRC_RD: begin
				if (grant.blt) begin
					n.st = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				s    = (mem_rdata & q.ent[E_AND]) ^ q.ent[E_XOR];
				n.sq = s;
				n.wd = merge(mode, s, q.dq);
				n.st = route(mode, s, cmask != 8'h00);
			end
			ST_DST_RD: begin
				if (grant.blt) begin
					n.st = ST_MERGE;
				end
			end
			ST_MERGE: begin
				d    = mem_rdata;
				n.dq = d;
				n.wd = merge(mode, q.sq, d);
				n.st = ST_DST_WR;
				// Only the first enabled hit of a blit is kept
				if (mode != M_COPY && mode <= M_NIBBLE && !q.cfound) begin
					if (mode == M_NIBBLE) begin
						if (q.sq[7:4] != 4'h0 && d[7:4] != 4'h0 && cmask[d[7:5]]) begin
							n.code   = {d[7:4], 4'h0};
							n.cfound = 1'b1;
						end else if (q.sq[3:0] != 4'h0 && d[3:0] != 4'h0
								&& cmask[d[3:1]]) begin
							n.code   = {4'h0, d[3:0]};
							n.cfound = 1'b1;
						end
					end else if (q.sq != 8'h00 && d != 8'h00 && cmask[d[7:5]]) begin
						n.code   = d;
						n.cfound = 1'b1;
					end
				end
			end
			ST_DST_WR: begin
				if (grant.blt) begin
					n.st = ST_ADV;
				end
			end
			ST_ADV: begin
				lastx = q.zx == zoomx;
				n.dst = q.dst + dx_step;
				if (!lastx) begin
					n.zx = q.zx + 3'h1;
				end else begin
					n.zx = 3'h0;
					if (q.x != width) begin
						n.x = q.x + 9'h001;
						if (q.ent[E_PAT][PAT_EN_BIT] && q.pc == q.ent[E_PAT][6:0]) begin
							n.src = q.srow;
							n.pc  = 7'h00;
						end else begin
							n.src = q.src + sx_step;
							n.pc  = q.pc + 7'h01;
						end
					end else begin
						// Row start plus pitch, independent of width
						n.x    = 9'h000;
						n.pc   = 7'h00;
						n.drow = q.drow + dy_step;
						n.dst  = q.drow + dy_step;
						if (q.zy != zoomy) begin
							n.zy  = q.zy + 3'h1;
							n.src = q.srow;
						end else begin
							n.zy   = 3'h0;
							n.srow = q.srow + sy_step;
							n.src  = q.srow + sy_step;
							if (q.y == q.ent[E_H]) begin
								done = 1'b1;
							end else begin
								n.y = q.y + 8'h01;
							end
						end
					end
				end
				// Constant source is reused, but a zero one still costs its read outside copy and AND
				skip = !lastx || q.ent[E_AND] == 8'h00;
				n.wd = merge(mode, q.sq, q.dq);
				if (done) begin
					n.st = ST_DONE;
				end else if (!skip || fast_zero(mode, q.sq)) begin
					n.st = ST_SRC_RD;
				end else begin
					n.st = route(mode, q.sq, cmask != 8'h00);
				end
			end
			ST_DONE: begin
				if (q.ent[E_MODE][MODE_NEXT_BIT]) begin
					n.lptr = q.lptr + ENTRY_STRIDE;
					n.idx  = 5'h00;
					n.lcnt = 5'h00;
					n.st   = ST_LOAD;
				end else begin
					n.busy = 1'b0;
					n.irq  = q.irq_en;
					n.st   = ST_IDLE;
				end
			end
			default: n.st = ST_IDLE;
		endcase

		// Address registered ahead of the access it serves
		if (n.st == ST_LOAD) begin
			n.maddr = n.lptr + {19'h00000, n.idx};
		end else if (n.st == ST_SRC_RD) begin
			n.maddr = n.src;
		end else begin
			n.maddr = n.dst;
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_src_read;
		q.st == ST_SRC_RD && grant.blt;
	endsequence

	sequence s_decide_copy;
		q.st == ST_DECIDE && mode == M_COPY;
	endsequence

	property p_win_first;
		grant.win |-> !grant.blt && !grant.dl;
	endproperty
	a_win_first: assert property (p_win_first) else $error("blitter granted over window");

	property p_lowres_slots;
		slot_req.ovl_active && slot_req.ovl_mode == OVL_LOW && q.slot[1:0] == 2'b10
			|-> !grant.ovl;
	endproperty
	a_lowres_slots: assert property (p_lowres_slots) else $error("low-res odd pair slot");

	property p_dl_reserve;
		$fell(slot_req.ovl_active) |=> dl_window [*8];
	endproperty
	a_dl_reserve: assert property (p_dl_reserve) else $error("list window too short");

	property p_load_len;
		q.st == ST_SETUP |-> q.lcnt == ENTRY_BYTES;
	endproperty
	a_load_len: assert property (p_load_len) else $error("entry load count wrong");

	property p_coll_clear;
		q.st == ST_SETUP |=> q.code == 8'h00 && !q.cfound;
	endproperty
	a_coll_clear: assert property (p_coll_clear) else $error("collision code not cleared");

	property p_copy_two;
		s_src_read ##1 s_decide_copy |=> q.st == ST_DST_WR;
	endproperty
	a_copy_two: assert property (p_copy_two) else $error("copy not read then write");

	property p_zero_skip;
		q.st == ST_DECIDE && mode == M_XOR && ((mem_rdata & q.ent[E_AND]) ^ q.ent[E_XOR]) == 8'h00
			|=> q.st == ST_ADV;
	endproperty
	a_zero_skip: assert property (p_zero_skip) else $error("zero source not fast");

	property p_start_busy;
		q.st == ST_IDLE && start_req |=> q.busy ##1 q.st == ST_LOAD;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start did not set busy");

	property p_hold_no_grant;
		blt_req && !grant.blt |=> $stable(q.st) && $stable(mem.addr);
	endproperty
	a_hold_no_grant: assert property (p_hold_no_grant) else $error("moved without grant");

endmodule // lmb_blitter

// ---- lmb_mem_model.sv ----
module lmb_mem_model
	import lmb_pkg::*;
(
	input  wire logic       mclk,
	input  wire lmb_mem_s   mem,
	input  wire lmb_grant_s grant,
	output logic [7:0]      mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] ram [0:4095];

	// Blank memory at start, no stale contents
	initial begin
		for (int i = 0; i < 4096; i++) ram[i] = 8'h00;
		mem_rdata = 8'h00;
	end

	// One access per granted cycle, read data one cycle later
	always @(posedge mclk) begin
		if (mem.req && grant.blt && mem.we) ram[mem.addr[11:0]] <= mem.wdata;
		// Bus flips when not answering, so stale data never looks valid
		if (mem.req && grant.blt && !mem.we) mem_rdata <= ram[mem.addr[11:0]];
		else mem_rdata <= ~mem_rdata;
	end
endmodule // lmb_mem_model

// ---- lmb_pkg.sv ----
package lmb_pkg;

	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] REG_LIST       = 8'h00;
	localparam logic [7:0] REG_CTRL       = 8'h04;
	localparam logic [7:0] REG_COLL       = 8'h08;
	localparam int         CTRL_START_BIT = 0;
	localparam int         CTRL_IRQEN_BIT = 1;
	localparam int         STAT_BUSY_BIT  = 0;

	// Setup entry layout, byte indices
	localparam logic [4:0] ENTRY_BYTES    = 5'h15;
	localparam logic [23:0] ENTRY_STRIDE  = 24'h000015;
	localparam int         E_SRC          = 0;
	localparam int         E_SY           = 3;
	localparam int         E_SX           = 5;
	localparam int         E_DST          = 6;
	localparam int         E_DY           = 9;
	localparam int         E_DX           = 11;
	localparam int         E_W            = 12;
	localparam int         E_W8           = 13;
	localparam int         E_H            = 14;
	localparam int         E_AND          = 15;
	localparam int         E_XOR          = 16;
	localparam int         E_CM           = 17;
	localparam int         E_ZOOM         = 18;
	localparam int         E_PAT          = 19;
	localparam int         E_MODE         = 20;
	localparam int         MODE_NEXT_BIT  = 3;
	localparam int         PAT_EN_BIT     = 7;

	// Memory slot pattern
	localparam logic [2:0] SLOT_WIN_RD    = 3'h1;
	localparam logic [2:0] SLOT_WIN_WR    = 3'h3;
	localparam logic [4:0] DL_RESERVE     = 5'h16;

	localparam logic [2:0] M_COPY   = 3'h0;
	localparam logic [2:0] M_BSTEN  = 3'h1;
	localparam logic [2:0] M_ADD    = 3'h2;
	localparam logic [2:0] M_OR     = 3'h3;
	localparam logic [2:0] M_AND    = 3'h4;
	localparam logic [2:0] M_XOR    = 3'h5;
	localparam logic [2:0] M_NIBBLE = 3'h6;

	typedef enum logic [1:0] {OVL_LOW, OVL_STD, OVL_HIGH, OVL_TEXT} lmb_ovl_e;

	typedef enum logic [3:0] {
		ST_IDLE, ST_LOAD, ST_SETUP, ST_SRC_RD, ST_DECIDE,
		ST_DST_RD, ST_MERGE, ST_DST_WR, ST_ADV, ST_DONE
	} lmb_state_e;

	// Requests of the other local memory users
	typedef struct packed {
		logic     win_rd;
		logic     win_wr;
		logic     ovl_active;
		lmb_ovl_e ovl_mode;
		logic     dl_req;
	} lmb_slot_req_s;

	typedef struct packed {
		logic win;
		logic ovl;
		logic dl;
		logic blt;
	} lmb_grant_s;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} lmb_mem_s;

endpackage

// ---- tb_local_memory_blitter.sv ----
module tb_local_memory_blitter
	import lmb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic          mclk;
	logic          rst;
	logic          wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]    wb_adr_i;
	logic [3:0]    wb_sel_i;
	logic [31:0]   wb_dat_i;
	logic [31:0]   wb_dat_o;
	logic          wb_ack_o;
	lmb_slot_req_s slot_req;
	lmb_grant_s    grant;
	logic          dl_window;
	lmb_mem_s      mem;
	logic [7:0]    mem_rdata;
	logic          list_done_irq;
	logic          win_rd, win_wr, ovl_on, dl_req, dl_on, ew, eo;
	lmb_ovl_e      ovl_mode;
	logic [2:0]    slot;
	logic [3:0]    sel_v;
	int            errors, total_checks, acc, irqs, dl_cnt, dl_len, cycles;

	assign slot_req = '{win_rd, win_wr, ovl_on, ovl_mode, dl_req};

	lmb_blitter u_lmb_blitter (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slot_req(slot_req), .grant(grant),
		.dl_window(dl_window), .mem(mem), .mem_rdata(mem_rdata), .list_done_irq(list_done_irq));

	lmb_mem_model u_lmb_mem_model (.mclk(mclk), .mem(mem), .grant(grant), .mem_rdata(mem_rdata));

	// Free-running clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Own copy of the slot counter, zero in the first cycle after reset
	always @(posedge mclk or posedge rst) begin
		if (rst) slot <= 3'h0;
		else slot <= slot + 3'h1;
	end

	// List fetcher steals slot 5 so the blitter waits longer
	always @(posedge mclk) dl_req <= dl_on && (slot == 3'h4);

	// Cycle budget; a hang ends the run as a failure
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			end_of_test();
		end
	end

	// Per-cycle grant check and event counts
	always @(negedge mclk) begin
		if (!rst) begin
			ew = (win_rd && slot == 3'h1) || (win_wr && slot == 3'h3);
			eo = ovl_on && ((ovl_mode == OVL_LOW) ? (slot[1:0] == 2'h0) : !slot[0]);
			chk(32'({grant.win, grant.ovl, grant.dl}), 32'({ew, eo, dl_req && !ew && !eo}));
			if (grant.blt) chk(32'({grant.win, grant.ovl, grant.dl}), 32'h0);
			if (mem.req && !ew && !eo && !dl_req) chk(32'(grant.blt), 32'h1);
			if (mem.req && grant.blt) acc++;
			if (list_done_irq) irqs++;
			if (dl_window) dl_cnt++;
			else if (dl_cnt != 0) begin
				dl_len = dl_cnt;
				dl_cnt = 0;
			end
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Classic single cycle; request held until ack is seen at a rising edge
	task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= sel_v;
		// Values seen here are those sampled at this edge
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic put(input int b, input logic [23:0] s, d, input logic [12:0] sy, dy,
		input logic [7:0] sx, dx, w, input logic w8, input logic [7:0] h, am, xm, cm, zm, pt, md);
		logic [7:0] e [21];
		e = '{s[7:0], s[15:8], s[23:16], sy[7:0], {3'h0, sy[12:8]}, sx, d[7:0], d[15:8], d[23:16],
			dy[7:0], {3'h0, dy[12:8]}, dx, w, {7'h0, w8}, h, am, xm, cm, zm, pt, md};
		for (int i = 0; i < 21; i++) u_lmb_mem_model.ram[12'(b + i)] = e[i];
	endtask

	// Start a list and wait for busy to drop
	task automatic run(input logic [23:0] base, input logic ie);
		logic [31:0] q;
		wbx(1'b1, REG_LIST, {8'h00, base}, q);
		acc = 0;
		irqs = 0;
		wbx(1'b1, REG_CTRL, {30'h0, ie, 1'b1}, q);
		wbx(1'b0, REG_CTRL, 32'h0, q);
		chk(32'(q[0]), 32'h1);
		do wbx(1'b0, REG_CTRL, 32'h0, q); while (q[0] !== 1'b0);
		chk(32'(irqs), 32'(ie));
	endtask

	task automatic regs();
		logic [31:0] q;
		wbx(1'b0, REG_LIST, 32'h0, q);
		chk(q, 32'h0);
		wbx(1'b0, REG_CTRL, 32'h0, q);
		chk(q, 32'h0);
		wbx(1'b1, REG_LIST, 32'hFFABCDEF, q);
		sel_v = 4'h2;
		wbx(1'b1, REG_LIST, 32'h00001200, q);
		sel_v = 4'hF;
		wbx(1'b0, REG_LIST, 32'h0, q);
		chk(q, 32'h00AB12EF);
		wbx(1'b1, 8'h0C, 32'hFFFFFFFF, q);
		wbx(1'b0, 8'h0C, 32'h0, q);
		chk(q, 32'h0);
		wbx(1'b1, REG_COLL, 32'h000000FF, q);
		wbx(1'b0, REG_COLL, 32'h0, q);
		chk(q, 32'h0);
	endtask

	// Every mode: non-zero source, masked-zero source, no collision mask
	task automatic modes();
		logic [31:0] q;
		logic [7:0]  cm, am;
		int          n;
		logic [7:0]  rnz [7] = '{8'h5A, 8'h5A, 8'h7D, 8'h7B, 8'h02, 8'h79, 8'h5A};
		logic [7:0]  rz [7] = '{8'h00, 8'h23, 8'h23, 8'h23, 8'h00, 8'h23, 8'h23};
		logic [7:0]  cnz [7] = '{8'h00, 8'h23, 8'h23, 8'h23, 8'h23, 8'h23, 8'h20};
		int          nnz [7] = '{2, 3, 3, 3, 3, 3, 3};
		int          nz [7] = '{2, 1, 1, 1, 2, 1, 1};
		for (int z = 0; z < 3; z++) begin
			for (int m = 0; m < 7; m++) begin
				cm = (z == 2) ? 8'h00 : 8'h02;
				am = (z == 1) ? 8'h00 : 8'hFF;
				n = (z == 1) ? nz[m] : nnz[m];
				if (z == 2 && m == 1) n = 2;
				put(32'h100, 24'h000300, 24'h000310, 13'h0, 13'h0, 8'h00, 8'h00, 8'h00, 1'b0,
					8'h00, am, 8'h00, cm, 8'h00, 8'h00, 8'(m));
				u_lmb_mem_model.ram[12'h300] = 8'h5A;
				u_lmb_mem_model.ram[12'h310] = 8'h23;
				ovl_mode <= lmb_ovl_e'(m[1:0]);
				run(24'h000100, m[0]);
				chk(32'(u_lmb_mem_model.ram[12'h310]), 32'((z == 1) ? rz[m] : rnz[m]));
				wbx(1'b0, REG_COLL, 32'h0, q);
				chk(q, 32'((z == 0) ? cnz[m] : 8'h00));
				chk(32'(acc), 32'(21 + n));
			end
		end
	endtask

	// Chained list: descending zoomed copy, pattern row, 512-byte fill
	task automatic twod();
		logic [7:0] v;
		int         r, c, x;
		for (int i = 0; i < 64; i++) u_lmb_mem_model.ram[12'h400 + 12'(i)] = 8'(i);
		u_lmb_mem_model.ram[12'hC00] = 8'h11;
		ovl_mode <= OVL_STD;
		put(32'h200, 24'h000412, 24'h000800, 13'h1FF0, 13'h0010, 8'hFF, 8'h01, 8'h02, 1'b0,
			8'h01, 8'h0F, 8'h30, 8'h00, 8'h01, 8'h00, 8'h08);
		put(32'h215, 24'h000420, 24'h000900, 13'h0, 13'h0, 8'h01, 8'h01, 8'h04, 1'b0,
			8'h00, 8'hFF, 8'h00, 8'h00, 8'h10, 8'h81, 8'h08);
		put(32'h22A, 24'h000300, 24'h000A00, 13'h0, 13'h0, 8'h00, 8'h01, 8'hFF, 1'b1,
			8'h00, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00);
		run(24'h000200, 1'b1);
		// Three loads, 6 reads plus 12 writes, 10 plus 10, then 1 read plus 512 writes
		chk(32'(acc), 32'd614);
		for (int i = 0; i < 12; i++) begin
			r = i / 6;
			c = (i % 6) / 2;
			x = i % 2;
			v = (u_lmb_mem_model.ram[12'h412 - 12'(r * 16 + c)] & 8'h0F) ^ 8'h30;
			chk(32'(u_lmb_mem_model.ram[12'h800 + 12'(r * 16 + c * 2 + x)]), 32'(v));
		end
		for (int k = 0; k < 5; k++) begin
			chk(32'(u_lmb_mem_model.ram[12'h900 + 12'(k)]), 32'(8'h20 + 8'(k % 2)));
		end
		chk(32'(u_lmb_mem_model.ram[12'h905]), 32'h0);
		chk(32'(u_lmb_mem_model.ram[12'hA00]), 32'h66);
		chk(32'(u_lmb_mem_model.ram[12'hBFF]), 32'h66);
		chk(32'(u_lmb_mem_model.ram[12'hC00]), 32'h11);
		ovl_on <= 1'b0;
		repeat (40) @(posedge mclk);
		chk(32'(dl_len), 32'd22);
	endtask

	task automatic end_of_test();
		if (errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence; window and overlay busy through every blit to squeeze the blitter
	initial begin
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i  = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		sel_v    = 4'hF;
		win_rd   = 1'b1;
		win_wr   = 1'b1;
		ovl_on   = 1'b1;
		ovl_mode = OVL_STD;
		dl_on    = 1'b1;
		dl_req   = 1'b0;
		rst      = 1'b1;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		regs();
		modes();
		twod();
		end_of_test();
	end
endmodule // tb_local_memory_blitter
